// [adcr_adc_model.sv]
// adc result port model: byte and serial readout of eight channels
// assumes: reader drives the strobes; a new sample waits on nextRes
module adcr_adc_model (
    input  wire logic         selectN,
    input  wire logic         readN,
    input  wire logic         serialClk,
    input  wire logic         interfaceSelect,
    input  wire logic         byteModeSelect,
    input  wire logic         byteOrderSelect,
    input  wire logic         adcBusy,
    input  wire logic [127:0] nextRes,
    output wire logic [7:0]   byteBus,
    output wire logic         serialOutFirst,
    output wire logic         serialOutSecond,
    output wire logic         firstChannelFlag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] res [8];
    logic [6:0]  bi = 7'h0, sb = 7'h0, bp;
    logic [3:0]  bit1;
    logic [2:0]  ca;
    logic        f14 = 1'h0;
    logic [10:0] cur, hold = 11'h0;
    // load at busy fall only, so a read under busy sees the old set
    always @(negedge adcBusy) begin
        for (int i = 0; i < 8; i++) res[i] = nextRes[16*i +: 16];
        sb = 7'h0;
        f14 = 1'h0;
    end
    always @(negedge selectN) bi = 7'h0;
    always @(negedge readN) if (!selectN) bi = bi + 7'h1;
    // serial position survives select pulses for per-channel framing
    always @(posedge serialClk) if (!selectN) sb = sb + 7'h1;
    always @(negedge serialClk) if (!selectN && sb == 7'hD) f14 = 1'h1;
    assign bp = bi - 7'h1;
    assign ca = 3'(sb / 7'hE);
    assign bit1 = 4'hF - 4'(sb % 7'hE);
    assign cur[10:3] = (bp[0] ^ byteOrderSelect) ? res[bp[3:1]][15:8]
                                                 : res[bp[3:1]][7:0];
    assign cur[2] = res[ca][bit1];
    assign cur[1] = res[ca + 3'h4][bit1];
    assign cur[0] = byteModeSelect ? (bi <= 7'h2) : (ca == 3'h0 && !f14);
    // released pins show the inverse of their last value, not a stale copy
    always @(posedge selectN) hold = ~cur;
    assign {byteBus, serialOutFirst, serialOutSecond, firstChannelFlag} =
        (selectN || !interfaceSelect) ? hold : cur;
endmodule // adcr_adc_model

// [adcr_half_timer.sv]
// down counter that times one half period of a strobe
// assumes: load is a one-cycle pulse at the start of each phase
module adcr_half_timer #(
    parameter int CYC = 4
) (
    input  logic clk,
    input  logic rstN,
    input  logic load,
    output logic done
);
    logic [7:0] count_q;

    if (CYC < 1 || CYC > 255) begin : g_check
        $error("half period must fit in eight bits");
    end

    // reload on load, then run down to zero and stay there
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count_q <= 8'h00;
        end else if (load) begin
            count_q <= 8'(CYC - 1);
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
        end
    end

    // masked during load so a stale zero never ends a fresh phase
    assign done = (count_q == 8'h00) && !load;
endmodule // adcr_half_timer

// [adcr_host_top.sv]
// host side reader for the adc result port: byte and serial readout
// assumes: software on axi4-lite, adc pins asynchronous to clk
module adcr_host_top #(
    parameter int HALF_CYC = adcr_pkg::STROBE_HALF_CYC
) (
    input  logic                            clk,
    input  logic                            nrst,
    input  logic [adcr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  logic                            s_axi_awvalid,
    output logic                            s_axi_awready,
    input  logic [adcr_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input  logic [3:0]                      s_axi_wstrb,
    input  logic                            s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  logic                            s_axi_bready,
    input  logic [adcr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  logic                            s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [adcr_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  logic                            s_axi_rready,
    output logic                            selectN,
    output logic                            readN,
    output logic                            serialClk,
    output logic                            interfaceSelect,
    output logic                            byteModeSelect,
    output logic                            byteOrderSelect,
    input  logic [adcr_pkg::BYTE_W-1:0]     byteBus,
    input  logic                            serialOutFirst,
    input  logic                            serialOutSecond,
    input  logic                            firstChannelFlag,
    input  logic                            adcBusy
);
    import adcr_pkg::*;

    if (HALF_CYC < 3 || HALF_CYC > 255) begin : g_check
        $error("strobe half period must be 3 to 255 cycles");
    end

    logic                  rstPipe_q, rstN_q;
    logic [SYNC_W-1:0]     pinSync;
    logic [BYTE_W-1:0]     byteIn;
    logic                  lineA, lineB, flagIn, busyIn;
    logic                  timerLoad_q, timerDone;
    adcr_state_type        state_q;
    logic [2:0]            chCnt_q;
    logic [3:0]            bitCnt_q;
    logic                  serialMode_q, dual_q, frame_q, msbFirst_q;
    logic [RESULT_BITS-1:0] shiftA_q, shiftB_q;
    logic [WORD_W-1:0]     results_q [NUM_CH];
    logic                  startPulse_q, startPend_q;
    logic                  done_q, flagErr_q, overlap_q;
    logic [7:0]            ctrl_q;
    logic [AXI_ADDR_W-1:0] awAddr_q;
    logic [AXI_DATA_W-1:0] wData_q;
    logic                  wLane0_q, awDone_q, wDone_q;
    logic [AXI_DATA_W-1:0] rdData;
    logic                  rdErr;
    logic [3:0]            lastBit;
    logic [2:0]            lastCh;
    logic                  flagWant;

    // reset enters asynchronously, leaves through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe_q <= 1'b0;
            rstN_q    <= 1'b0;
        end else begin
            rstPipe_q <= 1'b1;
            rstN_q    <= rstPipe_q;
        end
    end

    adcr_sync #(.W(SYNC_W)) u_sync (
        .clk   (clk),
        .rstN  (rstN_q),
        .async ({adcBusy, firstChannelFlag, serialOutSecond,
                 serialOutFirst, byteBus}),
        .sync  (pinSync)
    );

    assign byteIn = pinSync[BYTE_W-1:0];
    assign lineA  = pinSync[BYTE_W];
    assign lineB  = pinSync[BYTE_W+1];
    assign flagIn = pinSync[BYTE_W+2];
    assign busyIn = pinSync[BYTE_W+3];

    adcr_half_timer #(.CYC(HALF_CYC)) u_timer (
        .clk  (clk),
        .rstN (rstN_q),
        .load (timerLoad_q),
        .done (timerDone)
    );

    // shape of the frame for the mode that was latched at launch
    assign lastBit = serialMode_q ? 4'(RESULT_BITS - 1)
                                  : 4'(BYTES_PER_CH - 1);
    assign lastCh  = (serialMode_q && dual_q) ? 3'(NUM_CH / 2 - 1)
                                              : 3'(NUM_CH - 1);
    // flag is high only while channel 1 (and 5 on the second line) moves
    assign flagWant = (chCnt_q == 3'h0);

    // readout sequencer; starts only with busy low so select is already
    // high before the result registers reload
    always_ff @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            state_q      <= ST_IDLE;
            timerLoad_q  <= 1'b0;
            chCnt_q      <= 3'h0;
            bitCnt_q     <= 4'h0;
            serialMode_q <= 1'b0;
            dual_q       <= 1'b0;
            frame_q      <= 1'b0;
            msbFirst_q   <= 1'b1;
            shiftA_q     <= '0;
            shiftB_q     <= '0;
            startPend_q  <= 1'b0;
            done_q       <= 1'b0;
            flagErr_q    <= 1'b0;
            overlap_q    <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                results_q[i] <= '0;
            end
        end else begin
            timerLoad_q <= 1'b0;
            if (state_q != ST_IDLE && busyIn) begin
                overlap_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (startPend_q && !busyIn) begin
                        startPend_q  <= 1'b0;
                        serialMode_q <= ctrl_q[CTRL_SERIAL_BIT];
                        dual_q       <= ctrl_q[CTRL_DUAL_BIT];
                        frame_q      <= ctrl_q[CTRL_FRAME_BIT];
                        msbFirst_q   <= ctrl_q[CTRL_MSB_BIT];
                        chCnt_q      <= 3'h0;
                        bitCnt_q     <= 4'h0;
                        done_q       <= 1'b0;
                        flagErr_q    <= 1'b0;
                        overlap_q    <= 1'b0;
                        timerLoad_q  <= 1'b1;
                        state_q      <= ST_SETUP;
                    end
                end
                ST_SETUP, ST_GAP: begin
                    if (timerDone) begin
                        timerLoad_q <= 1'b1;
                        state_q     <= (state_q == ST_GAP) ? ST_SETUP
                                                           : ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (timerDone) begin
                        // sample at the end of the low phase
                        if (serialMode_q) begin
                            shiftA_q <= {shiftA_q[RESULT_BITS-2:0], lineA};
                            shiftB_q <= {shiftB_q[RESULT_BITS-2:0], lineB};
                        end else if ((bitCnt_q == 4'h0) == msbFirst_q) begin
                            results_q[chCnt_q][WORD_W-1:BYTE_W] <= byteIn;
                        end else begin
                            results_q[chCnt_q][BYTE_W-1:0] <= byteIn;
                        end
                        // flag drops at the last falling edge, skip that one
                        if ((!serialMode_q || bitCnt_q != lastBit)
                            && flagIn != flagWant) begin
                            flagErr_q <= 1'b1;
                        end
                        timerLoad_q <= 1'b1;
                        state_q     <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (timerDone) begin
                        timerLoad_q <= 1'b1;
                        if (bitCnt_q == lastBit) begin
                            bitCnt_q <= 4'h0;
                            if (serialMode_q) begin
                                results_q[chCnt_q] <= {shiftA_q,
                                                       PAD_BITS'(0)};
                                if (dual_q) begin
                                    results_q[3'(chCnt_q + 3'h4)] <=
                                        {shiftB_q, PAD_BITS'(0)};
                                end
                            end
                            if (chCnt_q == lastCh) begin
                                state_q <= ST_END;
                            end else begin
                                chCnt_q <= chCnt_q + 3'h1;
                                state_q <= (serialMode_q && frame_q)
                                           ? ST_GAP : ST_LOW;
                            end
                        end else begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            state_q  <= ST_LOW;
                        end
                    end
                end
                ST_END: begin
                    if (timerDone) begin
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // a start written in the launch cycle is kept, not lost
            if (startPulse_q) begin
                startPend_q <= 1'b1;
            end
        end
    end

    // pins follow the state one cycle later; clock idles high so the
    // first falling edge samples the msb driven at select fall
    always_ff @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            selectN   <= 1'b1;
            readN     <= 1'b1;
            serialClk <= 1'b1;
        end else begin
            selectN   <= (state_q == ST_IDLE) || (state_q == ST_GAP)
                         || (state_q == ST_END);
            readN     <= !(state_q == ST_LOW && !serialMode_q);
            serialClk <= !(state_q == ST_LOW && serialMode_q);
        end
    end

    // mode straps change only between frames
    always_ff @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            interfaceSelect <= 1'b1;
            byteModeSelect  <= 1'b1;
            byteOrderSelect <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            interfaceSelect <= 1'b1;
            byteModeSelect  <= !ctrl_q[CTRL_SERIAL_BIT];
            byteOrderSelect <= ctrl_q[CTRL_MSB_BIT];
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awDone_q      <= 1'b0;
            wDone_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= '0;
            wLane0_q      <= 1'b0;
            ctrl_q        <= CTRL_RESET;
            startPulse_q  <= 1'b0;
        end else begin
            startPulse_q <= 1'b0;
            if (s_axi_awready && s_axi_awvalid) begin
                awAddr_q      <= s_axi_awaddr;
                awDone_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!awDone_q) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                wData_q      <= s_axi_wdata;
                wLane0_q     <= s_axi_wstrb[0];
                wDone_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!wDone_q) begin
                s_axi_wready <= 1'b1;
            end
            if (awDone_q && wDone_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                if (awAddr_q[5:2] == CTRL_OFS[5:2]) begin
                    if (wLane0_q) begin
                        ctrl_q       <= wData_q[7:0] & CTRL_MASK;
                        startPulse_q <= wData_q[CTRL_START_BIT];
                    end
                end else if (awAddr_q[5:2] == STATUS_OFS[5:2]) begin
                    s_axi_bresp <= RESP_OKAY;
                end else if (awAddr_q < RESULT_OFS
                             || awAddr_q[5:2] >= 4'(NUM_CH + 2)) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awDone_q     <= 1'b0;
                wDone_q      <= 1'b0;
            end
        end
    end

    // read decode; unmapped words answer slave error with zero data
    always_comb begin
        rdData = '0;
        rdErr  = 1'b0;
        if (s_axi_araddr[5:2] == CTRL_OFS[5:2]) begin
            rdData[7:0] = ctrl_q;
        end else if (s_axi_araddr[5:2] == STATUS_OFS[5:2]) begin
            rdData[STAT_RUN_BIT]     = (state_q != ST_IDLE) || startPend_q;
            rdData[STAT_DONE_BIT]    = done_q;
            rdData[STAT_FLAGERR_BIT] = flagErr_q;
            rdData[STAT_BUSY_BIT]    = busyIn;
            rdData[STAT_OVERLAP_BIT] = overlap_q;
        end else if (s_axi_araddr >= RESULT_OFS
                     && s_axi_araddr[5:2] < 4'(NUM_CH + 2)) begin
            rdData[WORD_W-1:0] =
                results_q[3'(s_axi_araddr[5:2] - RESULT_OFS[5:2])];
        end else begin
            rdErr = 1'b1;
        end
    end

    // read channel: one read in flight, answer one cycle after address
    always_ff @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdData;
                s_axi_rresp   <= rdErr ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // strobe fall counters read only by the checks below
    logic [7:0] readFalls_q, sclkFalls_q;
    logic       readPrev_q, sclkPrev_q;
    always_ff @(posedge clk or negedge rstN_q) begin
        if (!rstN_q) begin
            readFalls_q <= 8'h00;
            sclkFalls_q <= 8'h00;
            readPrev_q  <= 1'b1;
            sclkPrev_q  <= 1'b1;
        end else begin
            readPrev_q <= readN;
            sclkPrev_q <= serialClk;
            if (state_q == ST_IDLE) begin
                readFalls_q <= 8'h00;
                sclkFalls_q <= 8'h00;
            end else begin
                if (readPrev_q && !readN) begin
                    readFalls_q <= readFalls_q + 8'h01;
                end
                if (sclkPrev_q && !serialClk) begin
                    sclkFalls_q <= sclkFalls_q + 8'h01;
                end
            end
        end
    end

    a_byte_pulse_total: assert property (
        @(posedge clk) disable iff (!rstN_q)
        (state_q == ST_END && timerDone && !serialMode_q)
            |-> readFalls_q == 8'(BYTES_TOTAL) && sclkFalls_q == 8'h00)
        else $error("byte frame did not give sixteen read pulses");

    a_sclk_total: assert property (
        @(posedge clk) disable iff (!rstN_q)
        (state_q == ST_END && timerDone && serialMode_q)
            |-> sclkFalls_q == (dual_q ? 8'(SCLK_DUAL) : 8'(SCLK_SINGLE)))
        else $error("serial frame clock count is wrong");

    a_sample_on_fall: assert property (
        @(posedge clk) disable iff (!rstN_q)
        (state_q == ST_LOW && timerDone && serialMode_q)
            |-> !serialClk && !selectN && $past(!serialClk, 2))
        else $error("serial bit sampled outside the clock low phase");

    a_select_idle_clk: assert property (
        @(posedge clk) disable iff (!rstN_q)
        $fell(selectN) |-> serialClk && readN ##1 serialClk && readN)
        else $error("strobe not idle high around select fall");

    a_gap_select_high: assert property (
        @(posedge clk) disable iff (!rstN_q)
        (state_q == ST_GAP && $past(state_q) == ST_GAP) |-> selectN)
        else $error("select low during a per-channel gap");

    a_chan_ascend: assert property (
        @(posedge clk) disable iff (!rstN_q)
        $changed(chCnt_q)
            |-> chCnt_q == 3'($past(chCnt_q) + 3'h1) || chCnt_q == 3'h0)
        else $error("channel order not ascending");

    a_launch_busy_low: assert property (
        @(posedge clk) disable iff (!rstN_q)
        (state_q == ST_IDLE ##1 state_q == ST_SETUP)
            |-> $past(busyIn) == 1'b0)
        else $error("frame launched while conversion busy");

endmodule // adcr_host_top

// [adcr_host_top_bench.sv]
// self-checking bench: register bus driver, read notes, adc model
// assumes: 20 MHz clock, model wired straight to the readout pins
module adcr_host_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import adcr_pkg::*;
    logic clk = 1'h0, nrst = 1'h0, adcBusy = 1'h0;
    logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic selectN, readN, serialClk, interfaceSelect, byteModeSelect;
    logic byteOrderSelect, serialOutFirst, serialOutSecond, firstChannelFlag;
    logic [7:0] byteBus;
    logic [127:0] nextRes = 128'h0, curRes;
    logic [33:0] expQ [$], note, got;
    logic [4:0] modes [5] = '{5'h05, 5'h01, 5'h03, 5'h0B, 5'h13};
    int err_total = 0, comparisons = 0, t, c;
    adcr_host_top #(.HALF_CYC(3)) adcr_host_top_i (.*);
    adcr_adc_model adcr_adc_model_i (.*);
    always #25 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a wait that ran out counts as a mismatch and closes the run
    task automatic bound(input int n);
        if (n >= 3000) begin
            err_total++;
            $display("BAD wait expected answer seen timeout");
            finish_test();
        end
    endtask
    // one write (w) or one read; each leaves its expected answer queued
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [33:0] e);
        int n;
        @(posedge clk);
        expQ.push_back(e);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= e[31:0];
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        n = 0;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            n++;
        end while (n < 3000 && !(s_axi_bvalid || s_axi_rvalid));
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        bound(n);
    endtask
    // new sample, start in mode m; with ov busy also spans the whole frame
    task automatic frame(input logic [4:0] m, input logic ov);
        int n, k;
        logic seen;
        nextRes = {$urandom, $urandom, $urandom, $urandom} & {8{16'hFFFC}};
        curRes = nextRes;
        adcBusy <= 1'h1;
        repeat (4) @(posedge clk);
        adcBusy <= 1'h0;
        xfer(1'h1, CTRL_OFS, 34'(m));
        // new sample only after the busy fall above has loaded the old one
        if (ov) nextRes = ~nextRes & {8{16'hFFFC}};
        seen = 1'h0;
        k = 0;
        for (n = 0; n < 3000 && k < 20; n++) begin
            @(posedge clk);
            seen |= !selectN;
            if (seen && ov) adcBusy <= (k < 10);
            k = (seen && selectN) ? k + 1 : 0;
        end
        bound(n);
    endtask
    // oldest note against each read or write answer as it is taken
    always @(posedge clk) begin
        if ((s_axi_rvalid && s_axi_rready)
            || (s_axi_bvalid && s_axi_bready)) begin
            note = expQ.pop_front();
            got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
                               : {s_axi_bresp, note[31:0]};
            comparisons++;
            if (got !== note) begin
                err_total++;
                $display("BAD resp expected %h seen %h", note, got);
            end
        end
    end
    initial begin
        void'($urandom(32'h5942));
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        for (t = 0; t < 5; t++) begin
            frame(modes[t], t == 4);
            for (c = 0; c < 8; c++)
                xfer(1'h0, RESULT_OFS + 6'(4 * c), 34'(curRes[16*c +: 16]));
            xfer(1'h0, STATUS_OFS, {29'h0, t == 4, 4'h2});
            $display("test %0d over", t);
        end
        xfer(1'h1, 6'h3C, {RESP_SLVERR, 32'h0});
        xfer(1'h0, 6'h3C, {RESP_SLVERR, 32'h0});
        xfer(1'h0, CTRL_OFS, 34'h12);
        finish_test();
    end
endmodule // adcr_host_top_bench

// [adcr_pkg.sv]
// constants, field positions and state codes of the adc result reader
// assumes: 20 MHz system clock, adc readout pins wired straight to the top
//
// What this block does
// - host gives two read pulses per channel, sixteen in total
// - msb at select fall, next bits on rise; host samples on fall
// - host gives 14 serial clocks per channel, channels ascending
// - host may hold select low throughout or frame each channel
// - with one line only, the host reads the first line
// - host raises select a margin before busy falls; the host only launches with busy low and flags busy in a frame as overlap
package adcr_pkg;

    // register bus
    localparam int         AXI_ADDR_W  = 6;
    localparam int         AXI_DATA_W  = 32;
    localparam logic [5:0] CTRL_OFS    = 6'h00;
    localparam logic [5:0] STATUS_OFS  = 6'h04;
    localparam logic [5:0] RESULT_OFS  = 6'h08;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register fields
    localparam int         CTRL_START_BIT  = 0;
    localparam int         CTRL_SERIAL_BIT = 1;
    localparam int         CTRL_MSB_BIT    = 2;
    localparam int         CTRL_DUAL_BIT   = 3;
    localparam int         CTRL_FRAME_BIT  = 4;
    localparam logic [7:0] CTRL_MASK       = 8'h1E;
    localparam logic [7:0] CTRL_RESET      = 8'h04;

    // status register fields
    localparam int STAT_RUN_BIT     = 0;
    localparam int STAT_DONE_BIT    = 1;
    localparam int STAT_FLAGERR_BIT = 2;
    localparam int STAT_BUSY_BIT    = 3;
    localparam int STAT_OVERLAP_BIT = 4;

    // readout shape
    localparam int NUM_CH       = 8;
    localparam int RESULT_BITS  = 14;
    localparam int PAD_BITS     = 2;
    localparam int WORD_W       = 16;
    localparam int BYTE_W       = 8;
    localparam int BYTES_PER_CH = 2;
    localparam int BYTES_TOTAL  = NUM_CH * BYTES_PER_CH;
    localparam int SCLK_SINGLE  = RESULT_BITS * NUM_CH;
    localparam int SCLK_DUAL    = RESULT_BITS * NUM_CH / 2;
    localparam int SYNC_W       = BYTE_W + 4;

    // strobe timing: half period of the read strobe and the serial clock
    localparam int CLK_PERIOD_NS   = 50;
    localparam int STROBE_HALF_NS  = 200;
    localparam int STROBE_HALF_CYC =
        (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_LOW   = 3'h2,
        ST_HIGH  = 3'h3,
        ST_GAP   = 3'h4,
        ST_END   = 3'h5
    } adcr_state_type;

endpackage

// [adcr_sync.sv]
// two flip-flop synchroniser, one stage pair per bit
// assumes: inputs are asynchronous pins, reset already synchronised
module adcr_sync #(
    parameter int W = 1
) (
    input  logic         clk,
    input  logic         rstN,
    input  logic [W-1:0] async,
    output logic [W-1:0] sync
);
    if (W < 1) begin : g_check
        $error("synchroniser width must be at least one");
    end

    // first stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        logic hold_q;
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                meta_q <= 1'b0;
                hold_q <= 1'b0;
            end else begin
                meta_q <= async[i];
                hold_q <= meta_q;
            end
        end
        assign sync[i] = hold_q;
    end
endmodule // adcr_sync
